// *** core/lcdt_top.sv ***
// Copper diagnostic test register page with APB slave
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "lcdt_cfg.svh"

// Operation
// - Gap length is field plus one, reset twelve
// - Count SOP during bytes 65-96
// - Count SOP during bytes 97-128
// - Count SOP during bytes 129-192
// - Count SOP after byte 192
// - Byte positions taken at GMII side
// - Counters saturate and clear on read
// - Adjust moves window start earlier
// - Polling code selects rate or off
// - Threshold is five times field minus 25
// - Threshold reached latches interrupt bit
// - Thermal interrupt only when enable set; collision interrupt needs only its mask bit
// - Manual mode drives acquire strobe
// - Reading is raw bits five to one
module lcdt_top #(
  parameter int unsigned SLOW_CYC = `LCDT_SLOW_CYC, // One second
  parameter int unsigned FAST_CYC = `LCDT_FAST_CYC  // Ten milliseconds
) (
  input  wire logic        pclk,          // Clock, 250 MHz
  input  wire logic        presetn,       // Async reset, low
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic        half_duplex,   // Link in half duplex
  input  wire logic        gmii_tx_en,    // GMII transmit frame
  input  wire logic        gmii_tx_byte,  // One byte sent
  input  wire logic        rx_sop,        // Receive start of packet
  input  wire logic [1:0]  sense_mode,    // Sensor control mode
  input  wire logic        temp_valid,    // Sensor sample done
  input  wire logic [5:0]  temp_raw,      // Raw sensor value
  output logic             sense_acquire, // Sensor acquire strobe
  output logic [8:0]       ipg_len_bytes, // Gap length in bytes
  output logic             irq            // Interrupt, high level
);

  // ----------------------------------------
  // State and bus decode
  // ----------------------------------------
  lcdt_pkg::lcdt_state_t s_q;   // Registered state
  lcdt_pkg::lcdt_state_t s_d;   // Next state

  logic [5:0] idx;              // Word index
  logic       rd_fire;          // Read data captured
  logic       wr_fire;          // Write completes
  logic       mapped;           // Address is decoded
  logic [15:0] rd_val;          // Selected register
  logic [1:0] poll;             // Polling code
  logic [4:0] thr;              // Threshold field
  logic [4:0] adj;              // Window adjust
  logic [8:0] win_first;        // First counted byte
  logic [3:0] hit;              // Bin struck this cycle
  logic [3:0] clr;              // Bin read this cycle
  logic       meet;             // Sample at threshold
  logic       tint_clr;         // Thermal register read
  logic [27:0] period;          // Active poll period

  assign idx     = paddr[7:2];
  // Read data is taken one cycle before ready, so read side effects
  // land on that edge; a transfer abandoned afterwards has already had them.
  assign rd_fire = psel & penable & ~s_q.pready & ~pwrite;
  assign wr_fire = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;
  assign poll    = s_q.therm[`LCDT_POLL_HI:`LCDT_POLL_LO];
  assign thr     = s_q.therm[`LCDT_THR_HI:`LCDT_THR_LO];
  assign adj     = s_q.wadj[`LCDT_WADJ_HI:`LCDT_WADJ_LO];
  assign win_first = `LCDT_BIN0_FIRST - {4'h0, adj};
  // Sample and threshold share the 5 C step and -25 C offset
  assign meet    = temp_valid & (temp_raw[5:1] >= thr);
  assign period  = poll[0] ? FAST_CYC[27:0] : SLOW_CYC[27:0];
  // Bus timing: the setup edge does nothing; the first access edge
  // captures read data and applies clear-on-read; pready and
  // pslverr then stand for one cycle and a write lands at the
  // edge that samples them. One wait state, always.
  // Limitation: a master that gives up after the capture edge
  // has already cleared the counters it was reading.

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  // Reserved bits read back as written, but read zero in status and mask; the flag and the reading
  // are patched in from their own flops
  always_comb begin
    mapped = 1'b1;
    rd_val = 16'h0000;
    case (idx)
      `LCDT_IDX_IPG:     rd_val = s_q.ipg;
      `LCDT_IDX_LC_LO:   rd_val = {s_q.lc[1], s_q.lc[0]};
      `LCDT_IDX_LC_HI:   rd_val = {s_q.lc[3], s_q.lc[2]};
      `LCDT_IDX_WADJ:    rd_val = s_q.wadj;
      `LCDT_IDX_THERM: begin
        rd_val = s_q.therm;
        rd_val[`LCDT_TINT_BIT] = s_q.tint;
        rd_val[4:0] = s_q.temp;
      end
      `LCDT_IDX_IRQ_STS: rd_val = {14'h0000, s_q.sts};
      `LCDT_IDX_IRQ_MSK: rd_val = {14'h0000, s_q.msk};
      default:           mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Collision binning at the GMII side
  // ----------------------------------------
  // Position counts bytes already handed to GMII in this frame
  // Bins are tried in byte order and are exclusive, so one
  // strike never counts twice. The adjust moves only the first
  // counted byte; the upper bounds do not follow it.
  always_comb begin
    hit = 4'h0;
    if (half_duplex & gmii_tx_en & rx_sop) begin
      if ({1'b0, s_q.pos} >= win_first && s_q.pos <= `LCDT_BIN0_LAST)
        hit[0] = 1'b1;
      else if (s_q.pos > `LCDT_BIN0_LAST && s_q.pos <= `LCDT_BIN1_LAST)
        hit[1] = 1'b1;
      else if (s_q.pos > `LCDT_BIN1_LAST && s_q.pos <= `LCDT_BIN2_LAST)
        hit[2] = 1'b1;
      else if (s_q.pos > `LCDT_BIN2_LAST)
        hit[3] = 1'b1;
    end
    clr[0]   = rd_fire & (idx == `LCDT_IDX_LC_LO);
    clr[1]   = clr[0];
    clr[2]   = rd_fire & (idx == `LCDT_IDX_LC_HI);
    clr[3]   = clr[2];
    tint_clr = rd_fire & (idx == `LCDT_IDX_THERM);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // APB handshake: ready one cycle after the access phase begins
    s_d.pready  = psel & penable & ~s_q.pready;
    s_d.pslverr = psel & penable & ~s_q.pready & ~mapped;
    if (rd_fire) begin
      s_d.prdata = {16'h0000, rd_val};
    end
    // Register writes
    if (wr_fire) begin
      case (idx)
        `LCDT_IDX_IPG:     s_d.ipg = pwdata[15:0];
        `LCDT_IDX_WADJ:    s_d.wadj = pwdata[15:0];
        `LCDT_IDX_THERM:   s_d.therm = pwdata[15:0] & `LCDT_THERM_WMASK;
        `LCDT_IDX_IRQ_MSK: s_d.msk = pwdata[1:0];
        default: begin
        end
      endcase
    end
    s_d.ipg_out = {1'b0, s_q.ipg[7:0]} + 9'h001;
    // Byte position, saturating, restarted between frames
    if (!gmii_tx_en) begin
      s_d.pos = 8'h00;
    end else if (gmii_tx_byte && s_q.pos != `LCDT_CNT_MAX) begin
      s_d.pos = s_q.pos + 8'h01;
    end
    // A read clears both bins of its word, never just one
    // Counters: a strike in the read cycle survives as one
    for (int i = 0; i < 4; i++) begin
      if (clr[i]) begin
        s_d.lc[i] = {7'h00, hit[i]};
      end else if (hit[i] && s_q.lc[i] != `LCDT_CNT_MAX) begin
        s_d.lc[i] = s_q.lc[i] + 8'h01;
      end
    end
    // Sensor reading and latched threshold flag, set wins
    if (temp_valid) begin
      s_d.temp = temp_raw[5:1];
    end
    if (meet) begin
      s_d.tint = 1'b1;
    end else if (tint_clr) begin
      s_d.tint = 1'b0;
    end
    // Status bits clear on a written one; an event in the same
    // cycle as the clear wins, so no event is ever lost
    // Sticky events: bit0 thermal, bit1 any late collision
    if (wr_fire && idx == `LCDT_IDX_IRQ_STS) begin
      s_d.sts = s_q.sts & ~pwdata[1:0];
    end
    if (meet && s_q.therm[`LCDT_TIE_BIT]) begin
      s_d.sts[0] = 1'b1;
    end
    if (|hit) begin
      s_d.sts[1] = 1'b1;
    end
    // Thermal event reaches the pin only while enabled
    s_d.irq = |(s_q.sts & s_q.msk & {1'b1, s_q.therm[`LCDT_TIE_BIT]});
    // The timer runs only while waiting. An acquire is held
    // until the sensor answers, so a stuck sensor stalls polling
    // rather than losing a sample.
    // Poll sequencer
    case (s_q.st)
      lcdt_pkg::LCDT_P_IDLE: begin
        s_d.tmr = 28'h0000000;
        if (!poll[1]) begin
          s_d.st = lcdt_pkg::LCDT_P_WAIT;
        end
      end
      lcdt_pkg::LCDT_P_WAIT: begin
        if (poll[1]) begin
          s_d.st = lcdt_pkg::LCDT_P_IDLE;
        end else if (s_q.tmr >= period - 28'h0000001) begin
          s_d.tmr = 28'h0000000;
          s_d.st  = lcdt_pkg::LCDT_P_ACQ;
        end else begin
          s_d.tmr = s_q.tmr + 28'h0000001;
        end
      end
      lcdt_pkg::LCDT_P_ACQ: begin
        if (temp_valid || poll[1]) begin
          s_d.st = lcdt_pkg::LCDT_P_WAIT;
        end
      end
      default: s_d.st = lcdt_pkg::LCDT_P_IDLE;
    endcase
    // Manual mode overrides the poll sequencer on the strobe
    if (sense_mode == `LCDT_MAN_SEL) begin
      s_d.acq = s_q.therm[`LCDT_MAN_BIT];
    end else begin
      s_d.acq = (s_d.st == lcdt_pkg::LCDT_P_ACQ);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Software reset of the PHY does not reach here: only presetn
  // Every output below is a field of this one register, so no
  // input reaches an output without a flop in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.ipg     <= `LCDT_IPG_RST;
      s_q.therm   <= `LCDT_THERM_RST;
      s_q.ipg_out <= `LCDT_IPG_OUT_RST;
      s_q.st      <= lcdt_pkg::LCDT_P_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.prdata;
  assign pready        = s_q.pready;
  assign pslverr       = s_q.pslverr;
  assign sense_acquire = s_q.acq;
  assign ipg_len_bytes = s_q.ipg_out;
  assign irq           = s_q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_ipg;
    wr_fire && idx == `LCDT_IDX_IPG;
  endsequence
  sequence s_rd_therm;
    rd_fire && idx == `LCDT_IDX_THERM && !meet;
  endsequence
  sequence s_rd_lo;
    rd_fire && idx == `LCDT_IDX_LC_LO && hit[1:0] == 2'h0;
  endsequence
  sequence s_rd_hi;
    rd_fire && idx == `LCDT_IDX_LC_HI && hit[3:2] == 2'h0;
  endsequence
  sequence s_at_win;
    half_duplex && gmii_tx_en && rx_sop && {1'b0, s_q.pos} == win_first;
  endsequence
  sequence s_timer_done;
    s_q.st == lcdt_pkg::LCDT_P_WAIT && !poll[1] && s_q.tmr >= period - 28'h0000001;
  endsequence
  sequence s_acq_wait;
    s_q.st == lcdt_pkg::LCDT_P_ACQ && !temp_valid && !poll[1] && sense_mode != `LCDT_MAN_SEL;
  endsequence

  // ----------------------------------------
  // Bus and gap length
  // ----------------------------------------
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");

  AST_IPG: assert property (s_wr_ipg |=> ##1 ipg_len_bytes == {1'b0, $past(pwdata[7:0], 2)} + 9'h001)
    else $error("gap length not field plus one");

  AST_GAP_LEN: assert property (ipg_len_bytes == {1'b0, $past(s_q.ipg[7:0])} + 9'h001)
    else $error("gap length lags its field");

  // ----------------------------------------
  // Late-collision bins
  // ----------------------------------------
  AST_BIN0: assert property (hit[0] && !clr[0] && s_q.lc[0] != 8'hFF |=> s_q.lc[0] == $past(s_q.lc[0]) + 8'h01)
    else $error("bin 65-96 did not count");

  AST_BIN0_TOP: assert property (half_duplex && gmii_tx_en && rx_sop && s_q.pos == 8'h60 |-> hit == 4'h1)
    else $error("byte 96 not binned low");

  AST_BIN_ONE: assert property ($onehot0(hit))
    else $error("strike counted in two bins");

  AST_FULL_DUPLEX: assert property (!half_duplex |-> hit == 4'h0)
    else $error("full duplex strike counted");

  AST_BIN1: assert property (half_duplex && gmii_tx_en && rx_sop && s_q.pos == 8'h61 |-> hit == 4'h2)
    else $error("byte 97 not binned high");

  AST_BIN2: assert property (half_duplex && gmii_tx_en && rx_sop && s_q.pos == 8'hC0 |-> hit == 4'h4)
    else $error("byte 192 not binned");

  AST_BIN3: assert property (half_duplex && gmii_tx_en && rx_sop && s_q.pos == 8'hC1 |-> hit == 4'h8)
    else $error("byte 193 not binned");

  AST_WIN_START: assert property (s_at_win |-> hit == 4'h1)
    else $error("window start byte not counted");

  AST_WIN_EARLY: assert property (half_duplex && rx_sop && {1'b0, s_q.pos} < win_first |-> hit == 4'h0)
    else $error("strike before window counted");

  AST_SAT: assert property (s_q.lc[1] == `LCDT_CNT_MAX && !clr[1] |=> s_q.lc[1] == `LCDT_CNT_MAX)
    else $error("counter wrapped");

  AST_RD_LO: assert property (s_rd_lo |=> s_q.lc[0] == 8'h00 && s_q.lc[1] == 8'h00)
    else $error("low bins not cleared by read");

  AST_RD_HI: assert property (s_rd_hi |=> s_q.lc[2] == 8'h00 && s_q.lc[3] == 8'h00)
    else $error("high bins not cleared by read");

  // ----------------------------------------
  // Sensor, polling and interrupt
  // ----------------------------------------
  AST_POLL_OFF: assert property (poll[1] && s_q.st == lcdt_pkg::LCDT_P_WAIT |=> s_q.st == lcdt_pkg::LCDT_P_IDLE)
    else $error("polling not disabled");

  AST_POLL_FIRE: assert property (s_timer_done |=> s_q.st == lcdt_pkg::LCDT_P_ACQ)
    else $error("poll period ran out without acquire");

  AST_ACQ_HOLD: assert property (s_acq_wait |=> sense_acquire)
    else $error("acquire dropped before sample");

  AST_LATCH: assert property ((meet ##1 !tint_clr) |-> s_q.tint ##1 s_q.tint)
    else $error("threshold flag not latched");

  AST_MANUAL: assert property (sense_mode == 2'h2 |=> sense_acquire == $past(s_q.therm[5]))
    else $error("manual strobe mismatch");

  AST_TEMP: assert property (temp_valid |=> s_q.temp == $past(temp_raw[5:1]))
    else $error("reading not raw 5:1");

  AST_TEMP_HOLD: assert property (!temp_valid |=> $stable(s_q.temp))
    else $error("reading moved without a sample");

  AST_CLR: assert property (s_rd_therm |=> !s_q.tint)
    else $error("flag not cleared by read");

  AST_TIE_OFF: assert property (!s_q.therm[`LCDT_TIE_BIT] && !s_q.sts[0] |=> !s_q.sts[0])
    else $error("thermal event set while disabled");

  AST_IRQ_GATE: assert property (!s_q.therm[`LCDT_TIE_BIT] && !s_q.sts[1] |=> !irq)
    else $error("interrupt raised while disabled");

endmodule : lcdt_top

// *** core/lcdt_cfg.svh ***
// Constants of the copper diagnostic test register page
`ifndef LCDT_CFG_SVH
`define LCDT_CFG_SVH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define LCDT_IDX_IPG      6'h13
`define LCDT_IDX_LC_LO    6'h17
`define LCDT_IDX_LC_HI    6'h18
`define LCDT_IDX_WADJ     6'h19
`define LCDT_IDX_THERM    6'h1A
`define LCDT_IDX_IRQ_STS  6'h1C
`define LCDT_IDX_IRQ_MSK  6'h1D
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define LCDT_IPG_RST      16'h000C
`define LCDT_IPG_OUT_RST  9'h00D
`define LCDT_THERM_RST    16'h1900
`define LCDT_THERM_WMASK  16'hFFA0
`define LCDT_THR_HI       12
`define LCDT_THR_LO       8
`define LCDT_POLL_HI      14
`define LCDT_POLL_LO      13
`define LCDT_TIE_BIT      7
`define LCDT_TINT_BIT     6
`define LCDT_MAN_BIT      5
`define LCDT_WADJ_HI      12
`define LCDT_WADJ_LO      8
`define LCDT_MAN_SEL      2'h2
// ----------------------------------------
// Late-collision bin limits (byte numbers)
// ----------------------------------------
`define LCDT_BIN0_FIRST   9'h041
`define LCDT_BIN0_LAST    8'h60
`define LCDT_BIN1_LAST    8'h80
`define LCDT_BIN2_LAST    8'hC0
`define LCDT_CNT_MAX      8'hFF
// ----------------------------------------
// Polling periods
// ----------------------------------------
`define LCDT_CLK_MHZ      250
`define LCDT_SLOW_MS      1000
`define LCDT_FAST_MS      10
`define LCDT_SLOW_CYC     (`LCDT_SLOW_MS * 1000 * `LCDT_CLK_MHZ)
`define LCDT_FAST_CYC     (`LCDT_FAST_MS * 1000 * `LCDT_CLK_MHZ)
`endif

// *** core/lcdt_pkg.sv ***
// Types of the copper diagnostic test register page
package lcdt_pkg;
  // ----------------------------------------
  // Poll sequencer states (Gray coded)
  // ----------------------------------------
  typedef enum logic [1:0] {
    LCDT_P_IDLE = 2'h0,
    LCDT_P_WAIT = 2'h1,
    LCDT_P_ACQ  = 2'h3
  } lcdt_poll_t;

  // ----------------------------------------
  // Whole state of the block
  // ----------------------------------------
  typedef struct packed {
    logic [15:0]      ipg;      // Gap register image
    logic [15:0]      wadj;     // Window adjust register image
    logic [15:0]      therm;    // Writable thermal bits
    logic [3:0][7:0]  lc;       // Late-collision bins
    logic [7:0]       pos;      // Bytes sent of current frame
    logic [4:0]       temp;     // Coarse reading
    logic             tint;     // Latched threshold flag
    logic [1:0]       sts;      // Sticky event bits
    logic [1:0]       msk;      // Event mask
    logic             irq;      // Interrupt output
    logic             acq;      // Sensor acquire strobe
    logic [27:0]      tmr;      // Poll timer
    lcdt_poll_t       st;       // Poll sequencer
    logic [8:0]       ipg_out;  // Gap length in bytes
    logic             pready;   // APB ready
    logic             pslverr;  // APB error
    logic [31:0]      prdata;   // APB read data
  } lcdt_state_t;
endpackage : lcdt_pkg

// *** testbench/tb_lcdt_top.sv ***
// Self-checking bench of the copper diagnostic test register page
`timescale 1ns/1ps
`include "lcdt_cfg.svh"

module tb_lcdt_top;
  // ----------------------------------------
  // Expected APB answers and addresses
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] d;                            // Expected read data
    logic        e;                            // Expected error flag
    logic        c;                            // Read data is compared
  } lcdt_exp_t;
  localparam logic [7:0] a_ipg = {`LCDT_IDX_IPG, 2'b00};     // Gap length
  localparam logic [7:0] a_lo  = {`LCDT_IDX_LC_LO, 2'b00};   // Low bins
  localparam logic [7:0] a_hi  = {`LCDT_IDX_LC_HI, 2'b00};   // High bins
  localparam logic [7:0] a_wa  = {`LCDT_IDX_WADJ, 2'b00};    // Window adjust
  localparam logic [7:0] a_th  = {`LCDT_IDX_THERM, 2'b00};   // Thermal control
  localparam logic [7:0] a_st  = {`LCDT_IDX_IRQ_STS, 2'b00}; // Event status
  localparam logic [7:0] a_mk  = {`LCDT_IDX_IRQ_MSK, 2'b00}; // Event mask

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;   // APB side
  logic [7:0]  paddr;                          // APB address
  logic [31:0] pwdata, prdata;                 // APB data
  logic        half_duplex, gmii_tx_en, gmii_tx_byte, rx_sop;          // Frame side
  logic [1:0]  sense_mode;                     // Sensor mode
  logic        temp_valid, sense_acquire, irq; // Sensor and interrupt
  logic [5:0]  temp_raw;                       // Raw sample
  logic [8:0]  ipg_len_bytes;                  // Gap in bytes
  lcdt_exp_t   exq[$];                         // Outstanding APB answers
  int          mismatches, n_tests, seed, k;   // Bookkeeping
  logic [7:0]  v;                              // Random field value
  logic [4:0]  thr;                            // Threshold field
  logic        flg;                            // Expected latched flag
  int          bounds[8] = '{64, 65, 96, 97, 128, 129, 192, 193}; // Bin edge bytes

  // Short counts keep polling within a short run
  lcdt_top #(.SLOW_CYC(40), .FAST_CYC(10)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .half_duplex(half_duplex), .gmii_tx_en(gmii_tx_en), .gmii_tx_byte(gmii_tx_byte),
    .rx_sop(rx_sop), .sense_mode(sense_mode), .temp_valid(temp_valid), .temp_raw(temp_raw),
    .sense_acquire(sense_acquire), .ipg_len_bytes(ipg_len_bytes), .irq(irq));

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // One APB transfer; the answer is noted for the monitor, never assumed in time
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee, input logic cd);
    int n;
    exq.push_back('{ed, ee, cd});
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge so a following call never drives twice at once
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] ed);
    apb(1'b0, a, 32'h0, ed, 1'b0, 1'b1);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0, 1'b0);
  endtask : wr

  // Sends n bytes, then a receive start while the last byte is out
  task automatic frame(input int n, input logic hd);
    half_duplex <= hd; gmii_tx_en <= 1'b1; gmii_tx_byte <= 1'b1;
    repeat (n) @(posedge pclk);
    gmii_tx_byte <= 1'b0; rx_sop <= 1'b1;
    @(posedge pclk);
    rx_sop <= 1'b0; gmii_tx_en <= 1'b0;
    @(posedge pclk);
  endtask : frame

  // Bounded wait for the acquire strobe to reach a level
  task automatic wait_acq(input logic lvl);
    int n;
    n = 0;
    while (sense_acquire !== lvl && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("sense_acquire", sense_acquire, lvl);
    if (sense_acquire !== lvl) end_of_test();
  endtask : wait_acq

  // ----------------------------------------
  // Monitor: each answer retires the oldest note
  // ----------------------------------------
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exq.size() == 0) chk("unexpected pready", 1'b1, 1'b0);
      else begin
        chk("pslverr", pslverr, exq[0].e);
        if (exq[0].c) chk("prdata", prdata, exq[0].d);
        void'(exq.pop_front());
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    half_duplex = 1'b0; gmii_tx_en = 1'b0; gmii_tx_byte = 1'b0; rx_sop = 1'b0;
    sense_mode = 2'h0; temp_valid = 1'b0; temp_raw = 6'h00;
    mismatches = 0; n_tests = 0;
    seed = $urandom(32'hCAC02964);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("ipg_len_bytes", ipg_len_bytes, 9'h00D);
    rd(a_ipg, 32'h0000000C);
    rd(a_wa, 32'h00000000);
    rd(a_th, 32'h00001900);
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b1, 1'b1);   // Unmapped read
    apb(1'b1, 8'h7C, 32'hFFFF, 32'h0, 1'b1, 1'b0); // Unmapped write
    // Fast polling, every ten cycles in this bench, then switched off
    wr(a_th, 32'h00003900);
    wait_acq(1'b1);
    temp_raw <= 6'h02; temp_valid <= 1'b1;
    @(posedge pclk);
    temp_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("sense_acquire", sense_acquire, 1'b0);
    wr(a_th, 32'h00005900);
    repeat (60) @(posedge pclk);
    chk("sense_acquire", sense_acquire, 1'b0);
    // Random gap lengths
    for (k = 0; k < 3; k++) begin
      v = 8'($urandom());
      wr(a_ipg, {24'h0, v});
      repeat (3) @(posedge pclk);
      chk("ipg_len_bytes", ipg_len_bytes, {1'b0, v} + 9'h001);
      rd(a_ipg, {24'h0, v});
    end
    // Bin boundaries, one frame each; full duplex never counts
    foreach (bounds[i]) frame(bounds[i], 1'b1);
    frame(70, 1'b0);
    rd(a_lo, 32'h00000202);
    rd(a_hi, 32'h00000102);
    rd(a_lo, 32'h00000000);
    rd(a_hi, 32'h00000000);
    // Window start moved two bytes earlier
    wr(a_wa, 32'h00000200);
    rd(a_wa, 32'h00000200);
    frame(62, 1'b1);
    frame(63, 1'b1);
    rd(a_lo, 32'h00000001);
    // Saturation: 260 strikes in one frame
    half_duplex <= 1'b1; gmii_tx_en <= 1'b1; gmii_tx_byte <= 1'b1;
    repeat (100) @(posedge pclk);
    gmii_tx_byte <= 1'b0;
    repeat (260) begin
      rx_sop <= 1'b1;
      @(posedge pclk);
      rx_sop <= 1'b0;
      @(posedge pclk);
    end
    gmii_tx_en <= 1'b0;
    @(posedge pclk);
    rd(a_lo, 32'h0000FF00);
    // Manual sensor with random samples against a random threshold
    sense_mode <= `LCDT_MAN_SEL;
    rd(a_st, 32'h00000002);                       // Collisions left a sticky event
    for (k = 0; k < 6; k++) begin
      thr = 5'($urandom());
      wr(a_th, {16'h0, 1'b0, 2'h2, thr, 1'b1, 1'b0, 1'b1, 5'h00});  // Bit 15 kept at reset value
      repeat (2) @(posedge pclk);
      chk("sense_acquire", sense_acquire, 1'b1);
      temp_raw <= 6'($urandom()); temp_valid <= 1'b1;
      @(posedge pclk);
      temp_valid <= 1'b0;
      flg = (temp_raw[5:1] >= thr);
      repeat (2) @(posedge pclk);
      rd(a_th, {16'h0, 1'b0, 2'h2, thr, 1'b1, flg, 1'b1, temp_raw[5:1]});
      rd(a_th, {16'h0, 1'b0, 2'h2, thr, 1'b1, 1'b0, 1'b1, temp_raw[5:1]});
    end
    // Interrupt: masked, unmasked, cleared
    wr(a_st, 32'h00000003);
    wr(a_th, 32'h00004080);
    temp_raw <= 6'h3F; temp_valid <= 1'b1;
    @(posedge pclk);
    temp_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("sense_acquire", sense_acquire, 1'b0);
    chk("irq", irq, 1'b0);                        // Masked
    rd(a_st, 32'h00000001);
    wr(a_mk, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b1);
    wr(a_st, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b0);
    // Thermal event with the enable bit low stays silent
    wr(a_th, 32'h00004000);
    temp_valid <= 1'b1;
    @(posedge pclk);
    temp_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1'b0);
    rd(a_st, 32'h00000000);
    // Slow polling: no strobe before the long period runs out
    sense_mode <= 2'h0;
    wr(a_th, 32'h00000000);
    repeat (25) @(posedge pclk);
    chk("sense_acquire", sense_acquire, 1'b0);
    wait_acq(1'b1);
    repeat (4) @(posedge pclk);
    chk("queue empty", exq.size(), 32'h0);
    end_of_test();
  end
endmodule : tb_lcdt_top
